// ---- design/bco_exec.sv ----
// Execution slice for bit probe-then-set, call, compares, decimal adjust and
// interrupt hold-off. Sits between the decoder and the working registers.
// Assumes operands are already fetched and valid with issue_valid_i.
`timescale 1ns/1ns
module bco_exec
  import bco_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  input  wire logic                issue_valid_i,
  output logic                     issue_ready_o,
  input  wire bco_op_t             op_i,
  input  wire logic [DATA_W-1:0]   base_i,
  input  wire logic [DATA_W-1:0]   src_i,
  input  wire logic                use_lit_i,
  input  wire logic [LIT5_W-1:0]   lit5_i,
  input  wire logic [BIT4_W-1:0]   bit_i,
  input  wire logic [TGT_W-1:0]    target_i,
  input  wire logic [HOLD_W-1:0]   hold_lit_i,
  input  wire logic [FLG_W-1:0]    flags_i,
  input  wire logic                next_two_word_i,
  output logic                     done_o,
  output logic                     wb_en_o,
  output logic [DATA_W-1:0]        wb_data_o,
  output logic [FLG_W-1:0]         flag_we_o,
  output logic [FLG_W-1:0]         flags_o,
  output logic                     pc_load_o,
  output logic [TGT_W-1:0]         pc_target_o,
  output logic                     skip_o,
  output logic                     int_block_o
);

  if (DATA_W < 8 || DATA_W > 32 || (DATA_W % 2) != 0) begin : g_bad_data_w
    $error("bco_exec: DATA_W must be even and between 8 and 32");
  end

  typedef enum logic [1:0] {
    BCO_ST_IDLE,
    BCO_ST_WAIT2,
    BCO_ST_WAIT1
  } bco_state_t;

  // Returns {carry, half carry, negative, wrap, zero, difference}; carry set means no borrow
  function automatic logic [DATA_W+4:0] bco_sub(input logic [DATA_W-1:0] a,
                                                input logic [DATA_W-1:0] b,
                                                input logic              cin);
    logic [DATA_W:0]   full;
    logic [4:0]        low;
    logic [DATA_W-1:0] d;
    logic              ovf;
    full = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, cin};
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    d    = full[DATA_W-1:0];
    ovf  = (a[DATA_W-1] != b[DATA_W-1]) && (d[DATA_W-1] != a[DATA_W-1]);
    bco_sub = {full[DATA_W], low[4], d[DATA_W-1], ovf, (d == '0), d};
  endfunction : bco_sub

  function automatic logic [FLG_W-1:0] bco_pack(input logic c, input logic hc, input logic n,
                                                input logic aw, input logic z);
    logic [FLG_W-1:0] f;
    f                 = '0;
    f[FLG_C]          = c;
    f[FLG_HALF_CARRY] = hc;
    f[FLG_N]          = n;
    f[FLG_ARITH_WRAP] = aw;
    f[FLG_Z]          = z;
    bco_pack          = f;
  endfunction : bco_pack

  bco_state_t          state_ff;
  bco_state_t          nxt_state;
  logic [HOLD_W-1:0]   hold_ff;
  logic                issue_fire;
  logic [DATA_W-1:0]   operand;
  logic [DATA_W-1:0]   lit_ext;
  logic [DATA_W+4:0]   diff;
  logic                carry_in;
  logic [DATA_W-1:0]   bit_mask;
  logic                probe_bit;
  logic                take_skip;
  logic [7:0]          adj_lo;
  logic                adj_carry;
  logic [8:0]          adj_sum;

  assign issue_ready_o = (state_ff == BCO_ST_IDLE);
  assign issue_fire    = issue_valid_i && issue_ready_o;
  assign int_block_o   = (hold_ff != HOLD_RST);

  assign lit_ext   = {{(DATA_W-LIT5_W){1'b0}}, lit5_i};
  assign bit_mask  = {{(DATA_W-1){1'b0}}, 1'b1} << bit_i;
  assign probe_bit = |(src_i & bit_mask);

  always_comb begin
    operand  = use_lit_i ? lit_ext : src_i;
    carry_in = 1'b1;
    if (op_i == BCO_OP_BORROW_CMP) begin
      carry_in = flags_i[FLG_C];
    end
  end

  // Zero compare uses the source as minuend against a zero subtrahend
  assign diff = (op_i == BCO_OP_ZERO_CMP) ? bco_sub(src_i, '0, 1'b1)
                                          : bco_sub(base_i, operand, carry_in);

  always_comb begin
    unique case (op_i)
      BCO_OP_SKIP_EQ: take_skip = (base_i == src_i);
      BCO_OP_SKIP_NE: take_skip = (base_i != src_i);
      BCO_OP_SKIP_GT: take_skip = ($signed(base_i) > $signed(src_i));
      BCO_OP_SKIP_LT: take_skip = ($signed(base_i) < $signed(src_i));
      default:        take_skip = 1'b0;
    endcase
  end

  // Decimal adjust acts on the low byte only, keeping the upper bits
  always_comb begin
    adj_lo    = src_i[7:0];
    adj_carry = flags_i[FLG_C];
    if (src_i[3:0] > BCD_NIB_MAX || flags_i[FLG_HALF_CARRY]) begin
      adj_lo = adj_lo + BCD_LO_FIX;
    end
    adj_sum = {1'b0, adj_lo};
    if (adj_lo[7:4] > BCD_NIB_MAX || flags_i[FLG_C]) begin
      adj_sum = {1'b0, adj_lo} + {1'b0, BCD_HI_FIX};
    end
    adj_carry = adj_carry | adj_sum[8];
  end

  // Sequencing of multi-cycle operations
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BCO_ST_IDLE: begin
        if (issue_fire) begin
          if (op_i == BCO_OP_CALL_LIT || op_i == BCO_OP_CALL_REG) begin
            nxt_state = BCO_ST_WAIT1;
          end else if (take_skip) begin
            nxt_state = next_two_word_i ? BCO_ST_WAIT2 : BCO_ST_WAIT1;
          end
        end
      end
      BCO_ST_WAIT2: nxt_state = BCO_ST_WAIT1;
      BCO_ST_WAIT1: nxt_state = BCO_ST_IDLE;
      default:      nxt_state = BCO_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_ff <= BCO_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Hold-off counter, one decrement per instruction cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hold_ff <= HOLD_RST;
    end else if (issue_fire && op_i == BCO_OP_HOLD_OFF) begin
      hold_ff <= hold_lit_i;
    end else if (hold_ff != HOLD_RST) begin
      hold_ff <= hold_ff - 1'b1;
    end
  end

  // Results, registered at the issue edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      done_o      <= 1'b0;
      wb_en_o     <= 1'b0;
      wb_data_o   <= '0;
      flag_we_o   <= FLG_NONE_MASK;
      flags_o     <= '0;
      pc_load_o   <= 1'b0;
      pc_target_o <= '0;
      skip_o      <= 1'b0;
    end else begin
      done_o    <= issue_fire;
      wb_en_o   <= 1'b0;
      flag_we_o <= FLG_NONE_MASK;
      pc_load_o <= 1'b0;
      skip_o    <= 1'b0;
      if (issue_fire) begin
        flags_o <= flags_i;
        unique case (op_i)
          BCO_OP_PROBE_SET_C: begin
            wb_en_o          <= 1'b1;
            wb_data_o        <= src_i | bit_mask;
            flag_we_o[FLG_C] <= 1'b1;
            flags_o[FLG_C]   <= probe_bit;
          end
          BCO_OP_PROBE_SET_Z: begin
            wb_en_o          <= 1'b1;
            wb_data_o        <= src_i | bit_mask;
            flag_we_o[FLG_Z] <= 1'b1;
            flags_o[FLG_Z]   <= ~probe_bit;
          end
          BCO_OP_CALL_LIT: begin
            pc_load_o   <= 1'b1;
            pc_target_o <= target_i;
          end
          BCO_OP_CALL_REG: begin
            pc_load_o   <= 1'b1;
            pc_target_o <= TGT_W'(src_i);
          end
          BCO_OP_SUB_CMP, BCO_OP_ZERO_CMP: begin
            flag_we_o <= FLG_ARITH_MASK;
            flags_o   <= bco_pack(diff[DATA_W+4], diff[DATA_W+3], diff[DATA_W+2],
                                  diff[DATA_W+1], diff[DATA_W]);
          end
          BCO_OP_BORROW_CMP: begin
            // Zero stays clear once an earlier word was non-zero
            flag_we_o <= FLG_ARITH_MASK;
            flags_o   <= bco_pack(diff[DATA_W+4], diff[DATA_W+3], diff[DATA_W+2],
                                  diff[DATA_W+1], diff[DATA_W] & flags_i[FLG_Z]);
          end
          BCO_OP_SKIP_EQ, BCO_OP_SKIP_NE, BCO_OP_SKIP_GT, BCO_OP_SKIP_LT: begin
            skip_o <= take_skip;
          end
          BCO_OP_DEC_ADJ: begin
            wb_en_o          <= 1'b1;
            wb_data_o        <= {src_i[DATA_W-1:8], adj_sum[7:0]};
            flag_we_o[FLG_C] <= 1'b1;
            flags_o[FLG_C]   <= adj_carry;
          end
          BCO_OP_HOLD_OFF: begin
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Cycle counter seen only by the checks below
  logic [1:0] wait_cnt_ff;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wait_cnt_ff <= WAIT_RST;
    end else if (issue_fire) begin
      wait_cnt_ff <= WAIT_RST;
    end else if (!issue_ready_o) begin
      wait_cnt_ff <= wait_cnt_ff + 1'b1;
    end
  end

  sequence s_call_issue;
    issue_fire && (op_i == BCO_OP_CALL_LIT || op_i == BCO_OP_CALL_REG);
  endsequence

  sequence s_skip_issue_1w;
    issue_fire && take_skip && !next_two_word_i;
  endsequence

  sequence s_skip_issue_2w;
    issue_fire && take_skip && next_two_word_i;
  endsequence

  AST_PROBE_C: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && op_i == BCO_OP_PROBE_SET_C) |=>
      (flags_o[FLG_C] == $past(probe_bit)) && wb_en_o && (flag_we_o == 5'h01)
      && ((wb_data_o & $past(bit_mask)) != '0))
    else $error("probe-then-set to carry wrong");

  AST_PROBE_Z: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && op_i == BCO_OP_PROBE_SET_Z) |=>
      (flags_o[FLG_Z] == !$past(probe_bit)) && wb_en_o && (flag_we_o == 5'h10))
    else $error("probe-then-set to zero wrong");

  AST_CALL_TWO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_call_issue |=> pc_load_o && (flag_we_o == 5'h00) && !issue_ready_o ##1 issue_ready_o)
    else $error("call did not take two cycles");

  AST_CMP_NO_WB: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && (op_i inside {BCO_OP_SUB_CMP, BCO_OP_ZERO_CMP, BCO_OP_BORROW_CMP,
                                 BCO_OP_SKIP_EQ, BCO_OP_SKIP_NE, BCO_OP_SKIP_GT, BCO_OP_SKIP_LT}))
      |=> !wb_en_o)
    else $error("compare wrote a register");

  AST_CMP_Z: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && op_i == BCO_OP_SUB_CMP) |=>
      (flags_o[FLG_Z] == ($past(base_i) == $past(operand))) && (flag_we_o == 5'h1F)
      && issue_ready_o)
    else $error("compare zero flag wrong");

  AST_BORROW_C: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && op_i == BCO_OP_BORROW_CMP && !flags_i[FLG_C] && base_i == operand)
      |=> !flags_o[FLG_C] && !flags_o[FLG_Z])
    else $error("borrow compare ignored inverted carry");

  AST_SKIP_1W: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_skip_issue_1w |=> skip_o ##1 issue_ready_o)
    else $error("single-word skip not two cycles");

  AST_SKIP_2W: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_skip_issue_2w |=> skip_o && !issue_ready_o ##1 (wait_cnt_ff == 2'h1) ##1 issue_ready_o)
    else $error("two-word skip not three cycles");

  AST_SKIP_GT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && op_i == BCO_OP_SKIP_GT) |=>
      (skip_o == ($signed($past(base_i)) > $signed($past(src_i)))) && (flag_we_o == 5'h00))
    else $error("greater skip decision wrong");

  AST_NO_SKIP_ONE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && op_i inside {BCO_OP_SKIP_EQ, BCO_OP_SKIP_NE} && !take_skip)
      |=> !skip_o && issue_ready_o)
    else $error("untaken skip stalled");

  AST_DEC_ADJ_C_ONLY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && op_i == BCO_OP_DEC_ADJ) |=> (flag_we_o == 5'h01) && wb_en_o
      && (wb_data_o[3:0] <= 4'h9) && (wb_data_o[7:4] <= 4'h9))
    else $error("decimal adjust result wrong");

  AST_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_fire && op_i == BCO_OP_HOLD_OFF && hold_lit_i == 14'h0003) |=>
      int_block_o [*3] ##1 !int_block_o)
    else $error("hold-off length wrong");

endmodule : bco_exec

// ---- design/bco_pkg.sv ----
// Package for the bit, call and compare execution slice of the 16-bit core.
// Assumes the instruction decoder presents one decoded operation at a time.
package bco_pkg;

  typedef enum logic [3:0] {
    BCO_OP_PROBE_SET_C,
    BCO_OP_PROBE_SET_Z,
    BCO_OP_CALL_LIT,
    BCO_OP_CALL_REG,
    BCO_OP_SUB_CMP,
    BCO_OP_ZERO_CMP,
    BCO_OP_BORROW_CMP,
    BCO_OP_SKIP_EQ,
    BCO_OP_SKIP_GT,
    BCO_OP_SKIP_LT,
    BCO_OP_SKIP_NE,
    BCO_OP_DEC_ADJ,
    BCO_OP_HOLD_OFF
  } bco_op_t;

  // Position of each flag in the five-bit flag vectors
  localparam int FLG_C          = 0;
  localparam int FLG_HALF_CARRY = 1;
  localparam int FLG_N          = 2;
  localparam int FLG_ARITH_WRAP = 3;
  localparam int FLG_Z          = 4;
  localparam int FLG_W          = 5;

  localparam logic [4:0] FLG_ARITH_MASK = 5'h1F;
  localparam logic [4:0] FLG_NONE_MASK  = 5'h00;

  // Operand field widths
  localparam int LIT5_W   = 5;
  localparam int BIT4_W   = 4;
  localparam int TGT_W    = 23;
  localparam int HOLD_W   = 14;

  // Instruction cycle counts
  localparam int CYC_SINGLE  = 1;
  localparam int CYC_CALL    = 2;
  localparam int CYC_SKIP_1W = 2;
  localparam int CYC_SKIP_2W = 3;

  // Decimal adjust constants
  localparam logic [3:0] BCD_NIB_MAX = 4'h9;
  localparam logic [7:0] BCD_LO_FIX  = 8'h06;
  localparam logic [7:0] BCD_HI_FIX  = 8'h60;

  localparam logic [HOLD_W-1:0] HOLD_RST = 14'h0000;
  localparam logic [1:0]        WAIT_RST = 2'h0;

endpackage : bco_pkg

// ---- verification/bco_regfile_model.sv ----
// Working register file and program counter model beyond the slice.
// Assumes writes and loads are one-cycle pulses from the slice.
`timescale 1ns/1ns
module bco_regfile_model
  import bco_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        wb_en_i,
  input  wire logic        pc_load_i,
  input  wire logic [22:0] pc_target_i,
  output logic      [22:0] pc_o,
  output int               wr_cnt_o
);
  // Counts commits so stray register writes show up at the end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_cnt_o <= 0;
      pc_o     <= 23'h000000;
    end else begin
      if (wb_en_i) begin
        wr_cnt_o <= wr_cnt_o + 1;
      end
      if (pc_load_i) begin
        pc_o <= pc_target_i;
      end
    end
  end
endmodule : bco_regfile_model

// ---- verification/bco_exec_tb_top.sv ----
// Self-checking bench for the bit, call and compare execution slice.
// Assumes one answer per taken issue, one cycle after the issue edge.
`timescale 1ns/1ns
module bco_exec_tb_top
  import bco_pkg::*;
;
  typedef struct {
    logic        wb, pl, sk;
    logic [15:0] wd;
    logic [4:0]  we, fl;
    logic [22:0] pt;
    int          st, ho;
  } bco_exp_t;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i, issue_valid_i, use_lit_i, next_two_word_i;
  bco_op_t     op_i;
  logic [15:0] base_i, src_i, wb_data_o;
  logic [4:0]  lit5_i, flags_i, flag_we_o, flags_o;
  logic [3:0]  bit_i;
  logic [22:0] target_i, pc_target_o, m_pc, lastpc;
  logic [13:0] hold_lit_i;
  logic        issue_ready_o, done_o, wb_en_o, pc_load_o, skip_o, int_block_o;
  int          m_wr, n_tests, n_mismatch, cyc, nwr, i, k;
  logic [31:0] seed, r, s;
  bco_exp_t    q[$];
  bco_exp_t    me;
  bco_op_t     cops[7] = '{BCO_OP_SUB_CMP, BCO_OP_ZERO_CMP, BCO_OP_BORROW_CMP, BCO_OP_SKIP_EQ,
                           BCO_OP_SKIP_GT, BCO_OP_SKIP_LT, BCO_OP_SKIP_NE};
  logic [15:0] dv[4] = '{16'h1234, 16'h002A, 16'h00A5, 16'h0011};
  logic [4:0]  df[4] = '{5'h00, 5'h00, 5'h00, 5'h03};

  bco_exec #(.DATA_W(16)) uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .issue_valid_i(issue_valid_i),
    .issue_ready_o(issue_ready_o), .op_i(op_i), .base_i(base_i), .src_i(src_i),
    .use_lit_i(use_lit_i), .lit5_i(lit5_i), .bit_i(bit_i), .target_i(target_i),
    .hold_lit_i(hold_lit_i), .flags_i(flags_i), .next_two_word_i(next_two_word_i),
    .done_o(done_o), .wb_en_o(wb_en_o), .wb_data_o(wb_data_o), .flag_we_o(flag_we_o),
    .flags_o(flags_o), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
    .skip_o(skip_o), .int_block_o(int_block_o));

  bco_regfile_model model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_en_i(wb_en_o),
    .pc_load_i(pc_load_o), .pc_target_i(pc_target_o), .pc_o(m_pc), .wr_cnt_o(m_wr));

  always #10 clk_sys_i = ~clk_sys_i;

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Flags carry, half carry, negative, wrap, zero from bit 0; cb is the borrow in
  function automatic logic [4:0] subf(logic [15:0] a, b, logic cb, logic zin);
    logic [16:0] d;
    logic [4:0]  n;
    d = {1'b0, a} - {1'b0, b} - 17'(cb);
    n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cb);
    return {(d[15:0] == 16'h0000) & zin, (a[15] ^ b[15]) & (d[15] ^ a[15]), d[15], ~n[4], ~d[16]};
  endfunction : subf

  // Only for values where both nibble corrections are unambiguous
  function automatic logic [16:0] bcd_fix_ref(logic [15:0] v, logic [4:0] f);
    logic [8:0] t;
    t = {1'b0, v[7:0]};
    if (v[3:0] > 4'h9 || f[1]) t = t + 9'h006;
    if (t[7:4] > 4'h9 || f[0] || t[8]) t = t + 9'h060;
    return {f[0] | t[8], v[15:8], t[7:0]};
  endfunction : bcd_fix_ref

  task automatic issue(bco_op_t op, logic [15:0] b, sv, logic ul, logic [4:0] l5, logic [3:0] bt,
                       logic [22:0] tg, logic [13:0] hl, logic [4:0] f, logic tw);
    bco_exp_t    e;
    logic [15:0] sb;
    logic [16:0] d;
    sb = ul ? {11'h000, l5} : sv;
    d = bcd_fix_ref(sv, f);
    e = '{0, 0, 0, 16'h0000, 5'h00, 5'h00, 23'h000000, 0, 0};
    case (op)
      BCO_OP_PROBE_SET_C: e = '{1, 0, 0, sv | (16'h0001 << bt), 5'h01, {4'h0, sv[bt]}, 0, 0, 0};
      BCO_OP_PROBE_SET_Z: e = '{1, 0, 0, sv | (16'h0001 << bt), 5'h10, {~sv[bt], 4'h0}, 0, 0, 0};
      BCO_OP_CALL_LIT:    e = '{0, 1, 0, 0, 5'h00, 5'h00, tg, 1, 0};
      BCO_OP_CALL_REG:    e = '{0, 1, 0, 0, 5'h00, 5'h00, {7'h00, sv}, 1, 0};
      BCO_OP_SUB_CMP:     e = '{0, 0, 0, 0, 5'h1F, subf(b, sb, 1'b0, 1'b1), 0, 0, 0};
      BCO_OP_ZERO_CMP:    e = '{0, 0, 0, 0, 5'h1F, subf(sv, 16'h0000, 1'b0, 1'b1), 0, 0, 0};
      BCO_OP_BORROW_CMP:  e = '{0, 0, 0, 0, 5'h1F, subf(b, sb, ~f[0], f[4]), 0, 0, 0};
      BCO_OP_SKIP_EQ:     e.sk = (b == sv);
      BCO_OP_SKIP_NE:     e.sk = (b != sv);
      BCO_OP_SKIP_GT:     e.sk = ($signed(b) > $signed(sv));
      BCO_OP_SKIP_LT:     e.sk = ($signed(b) < $signed(sv));
      BCO_OP_DEC_ADJ:     e = '{1, 0, 0, d[15:0], 5'h01, {4'h0, d[16]}, 0, 0, 0};
      BCO_OP_HOLD_OFF:    e.ho = hl;
      default:            e.st = 0;
    endcase
    if (e.sk) e.st = tw ? 2 : 1;
    e.fl = (f & ~e.we) | (e.fl & e.we);
    if (e.wb) nwr++;
    if (e.pl) lastpc = e.pt;
    q.push_back(e);
    issue_valid_i <= 1'b1;
    op_i <= op;
    base_i <= b;
    src_i <= sv;
    use_lit_i <= ul;
    lit5_i <= l5;
    bit_i <= bt;
    target_i <= tg;
    hold_lit_i <= hl;
    flags_i <= f;
    next_two_word_i <= tw;
    @(posedge clk_sys_i);
    if (e.st + e.ho > 0) begin
      issue_valid_i <= 1'b0;
      repeat (e.st + e.ho + (e.ho > 0)) @(posedge clk_sys_i);
    end
  endtask : issue

  // Result watcher: oldest note against each answer
  initial begin
    forever begin
      @(negedge clk_sys_i);
      if (done_o === 1'b1) begin
        if (q.size() == 0) chk(32'h00000001, 32'h00000000);
        me = q.pop_front();
        chk(wb_en_o, me.wb);
        if (me.wb) chk(wb_data_o, me.wd);
        chk(flag_we_o, me.we);
        chk(flags_o, me.fl);
        chk(pc_load_o, me.pl);
        if (me.pl) chk(pc_target_o, me.pt);
        chk(skip_o, me.sk);
        for (k = 0; k < me.st; k++) begin
          chk(issue_ready_o, 1'b0);
          @(negedge clk_sys_i);
        end
        chk(issue_ready_o, 1'b1);
        for (k = 0; k < me.ho; k++) begin
          chk(int_block_o, 1'b1);
          @(negedge clk_sys_i);
        end
        if (me.ho > 0) chk(int_block_o, 1'b0);
      end
    end
  end

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    seed = 32'h00017258;
    rst_n_i = 1'b0;
    issue_valid_i = 1'b0;
    op_i = BCO_OP_SUB_CMP;
    base_i = 16'h0000;
    src_i = 16'h0000;
    use_lit_i = 1'b0;
    lit5_i = 5'h00;
    bit_i = 4'h0;
    target_i = 23'h000000;
    hold_lit_i = 14'h0000;
    flags_i = 5'h00;
    next_two_word_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 8; i++) begin
      r = rnd();
      s = rnd();
      issue(i[0] ? BCO_OP_PROBE_SET_Z : BCO_OP_PROBE_SET_C, r[15:0], r[31:16], 1'b0, 5'h00,
            (i < 2) ? 4'h0 : (i < 4) ? 4'hF : s[3:0], 23'h000000, 14'h0000, s[8:4], 1'b0);
    end
    $display("test probe done");
    issue(BCO_OP_CALL_LIT, r[15:0], r[31:16], 1'b0, 5'h00, 4'h0, 23'h7FFFFF, 14'h0000, s[4:0], 1'b0);
    issue(BCO_OP_CALL_REG, r[15:0], 16'hFFFE, 1'b0, 5'h00, 4'h0, 23'h000000, 14'h0000, s[9:5], 1'b0);
    $display("test call done");
    for (i = 0; i < 70; i++) begin
      r = rnd();
      s = rnd();
      if (i < 14) r = (i < 7) ? 32'h00018000 : 32'h00000000;
      if (i >= 14 && s[20]) r[31:16] = r[15:0];
      if (i < 14) s[21] = 1'b0;
      if (i < 14) s[0] = ~i[0];
      issue(cops[i % 7], r[15:0], r[31:16], s[21], s[26:22], 4'h0, 23'h000000, 14'h0000, s[4:0], s[27]);
    end
    $display("test compare done");
    for (i = 0; i < 4; i++) begin
      issue(BCO_OP_DEC_ADJ, dv[i], dv[i], 1'b0, 5'h00, 4'h0, 23'h000000, 14'h0000, df[i], 1'b0);
    end
    $display("test decimal done");
    issue(BCO_OP_HOLD_OFF, 16'h0000, 16'h0000, 1'b0, 5'h00, 4'h0, 23'h000000, 14'h0001, 5'h1F, 1'b0);
    issue(BCO_OP_HOLD_OFF, 16'h0000, 16'h0000, 1'b0, 5'h00, 4'h0, 23'h000000, 14'h0003, 5'h15, 1'b0);
    issue(BCO_OP_HOLD_OFF, 16'h0000, 16'h0000, 1'b0, 5'h00, 4'h0, 23'h000000, 14'h3FFF, 5'h0A, 1'b0);
    $display("test holdoff done");
    issue_valid_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk(q.size(), 0);
    chk(m_wr, nwr);
    chk(m_pc, lastpc);
    results();
  end
endmodule : bco_exec_tb_top
